/* File: hdl/sce_pkg.sv */
// Purpose: Constants and state type of the special character encoder.
// Assumes: Codes are the 8-bit value {y[2:0], x[4:0]} of the name Cx.y.
// Notes:   Ten-bit characters are {a,b,c,d,e,i,f,g,h,j}, a in bit 9.
package sce_pkg;

  // ---------------------------------------------------------------
  // Host special character codes, primary form.
  // ---------------------------------------------------------------
  localparam logic [7:0] SCE_C_K28_MAX   = 8'h07;  // C0.0..C7.0
  localparam logic [7:0] SCE_C_K23_7     = 8'h08;  // C8.0
  localparam logic [7:0] SCE_C_K27_7     = 8'h09;  // C9.0
  localparam logic [7:0] SCE_C_K29_7     = 8'h0A;  // C10.0
  localparam logic [7:0] SCE_C_K30_7     = 8'h0B;  // C11.0
  localparam logic [7:0] SCE_C_EOF_HELP  = 8'h22;  // C2.1
  localparam logic [7:0] SCE_C_VIOL_SYM  = 8'hE0;  // C0.7
  localparam logic [7:0] SCE_C_K28_5_NEG = 8'hE1;  // C1.7
  localparam logic [7:0] SCE_C_K28_5_POS = 8'hE2;  // C2.7
  localparam logic [7:0] SCE_C_RD_VIOL   = 8'hE4;  // C4.7

  // ---------------------------------------------------------------
  // Alternate codes: the plain Kxx.y byte values.
  // ---------------------------------------------------------------
  localparam logic [4:0] SCE_A_K28_LOW   = 5'h1C;  // K28.y = {y, 1C}
  localparam logic [7:0] SCE_A_K23_7     = 8'hF7;
  localparam logic [7:0] SCE_A_K27_7     = 8'hFB;
  localparam logic [7:0] SCE_A_K29_7     = 8'hFD;
  localparam logic [7:0] SCE_A_K30_7     = 8'hFE;

  // ---------------------------------------------------------------
  // Ten-bit characters; NEG entries are the negative running disparity form, POS entries the positive.
  // ---------------------------------------------------------------
  localparam logic [5:0] SCE_K28_6B_NEG  = 6'h0F;  // 001111
  localparam logic [9:0] SCE_K23_7_NEG   = 10'h3A8; // 111010 1000
  localparam logic [9:0] SCE_K27_7_NEG   = 10'h368; // 110110 1000
  localparam logic [9:0] SCE_K29_7_NEG   = 10'h2E8; // 101110 1000
  localparam logic [9:0] SCE_K30_7_NEG   = 10'h1E8; // 011110 1000
  localparam logic [9:0] SCE_K28_5_NEG   = 10'h0FA; // 001111 1010
  localparam logic [9:0] SCE_K28_5_POS   = 10'h305; // 110000 0101
  localparam logic [9:0] SCE_RDV_AT_NEG  = 10'h375; // 110111 0101
  localparam logic [9:0] SCE_RDV_AT_POS  = 10'h08A; // 001000 1010
  // Five equal bits in the 6b block never occur in a valid character.
  localparam logic [9:0] SCE_CRV_AT_NEG  = 10'h3E4; // 111110 0100
  localparam logic [9:0] SCE_CRV_AT_POS  = 10'h01B; // 000001 1011

  // ---------------------------------------------------------------
  // Encoder state.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rd_pos;    // Current running disparity is positive.
    logic       lsb_pend;  // Next data byte gets its LSB forced.
    logic [9:0] chr;       // Character handed to the serializer.
    logic       rsv;       // A reserved code was just replaced.
  } sce_state_s;

  localparam logic       SCE_RST_RD  = 1'b0;
  localparam sce_state_s SCE_RST     = '{rd_pos:   SCE_RST_RD,
                                         lsb_pend: 1'b0,
                                         chr:      SCE_K28_5_NEG,
                                         rsv:      1'b0};

endpackage

/* File: hdl/sce_encoder.sv */
// Purpose: 8B/10B transmit encoder with special characters for one lane.
// Assumes: Host inputs are on clk_sys; one character taken per clock.
// Notes:   Idle clocks send K28.5 fill; running disparity spans all.
//          Reserved codes go out as the violation symbol and pulse rsv_code.
//
// Contract
// - Disparity violation code sends a character whose polarity defies RD.
// - End-of-frame helper sends K28.5, then forces next LSB from RD.
// - Violation symbol sends an invalid character, still under RD rules.
// - Forced negative code always sends negative K28.5.
// - Forced positive code always sends positive K28.5.
// - K28.5 is sent as fill whenever no character is presented.
// - A special code is the 8-bit input value, 00 to FF.
// - Primary and alternate code forms give identical output.
`timescale 1ns/1ps
`default_nettype none

module sce_encoder
  import sce_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       tx_valid,
  input  wire logic       tx_special,
  input  wire logic [7:0] tx_byte,
  output logic      [9:0] ser_char,
  output logic            ser_rd_pos,
  output logic            rsv_code
);
  import sce_pkg::*;

  // ---------------------------------------------------------------
  // Code tables.
  // ---------------------------------------------------------------
  // Tables hold the forms sent at negative disparity.
  function automatic logic [5:0] six_neg(input logic [4:0] x);
    case (x)
      5'h00: six_neg = 6'h27;  5'h01: six_neg = 6'h1D;
      5'h02: six_neg = 6'h2D;  5'h03: six_neg = 6'h31;
      5'h04: six_neg = 6'h35;  5'h05: six_neg = 6'h29;
      5'h06: six_neg = 6'h19;  5'h07: six_neg = 6'h38;
      5'h08: six_neg = 6'h39;  5'h09: six_neg = 6'h25;
      5'h0A: six_neg = 6'h15;  5'h0B: six_neg = 6'h34;
      5'h0C: six_neg = 6'h0D;  5'h0D: six_neg = 6'h2C;
      5'h0E: six_neg = 6'h1C;  5'h0F: six_neg = 6'h17;
      5'h10: six_neg = 6'h1B;  5'h11: six_neg = 6'h23;
      5'h12: six_neg = 6'h13;  5'h13: six_neg = 6'h32;
      5'h14: six_neg = 6'h0B;  5'h15: six_neg = 6'h2A;
      5'h16: six_neg = 6'h1A;  5'h17: six_neg = 6'h3A;
      5'h18: six_neg = 6'h33;  5'h19: six_neg = 6'h26;
      5'h1A: six_neg = 6'h16;  5'h1B: six_neg = 6'h36;
      5'h1C: six_neg = 6'h0E;  5'h1D: six_neg = 6'h2E;
      5'h1E: six_neg = 6'h1E;  default: six_neg = 6'h2B;
    endcase
  endfunction

  function automatic logic [3:0] four_neg(input logic [2:0] y);
    case (y)
      3'h0: four_neg = 4'hB;  3'h1: four_neg = 4'h9;
      3'h2: four_neg = 4'h5;  3'h3: four_neg = 4'hC;
      3'h4: four_neg = 4'hD;  3'h5: four_neg = 4'hA;
      3'h6: four_neg = 4'h6;  default: four_neg = 4'hE;
    endcase
  endfunction

  // K28.y trailing nibble after the 001111 block.
  function automatic logic [3:0] k28_four(input logic [2:0] y);
    case (y)
      3'h0: k28_four = 4'h4;  3'h1: k28_four = 4'h9;
      3'h2: k28_four = 4'h5;  3'h3: k28_four = 4'h3;
      3'h4: k28_four = 4'h2;  3'h5: k28_four = 4'hA;
      3'h6: k28_four = 4'h6;  default: k28_four = 4'h8;
    endcase
  endfunction

  function automatic logic [3:0] ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, v[i]};
    end
    ones = n;
  endfunction

  // ---------------------------------------------------------------
  // Data character encoder.
  // ---------------------------------------------------------------
  function automatic logic [9:0] enc_data(input logic [7:0] b,
                                          input logic       rdp);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [3:0] w6;
    logic       rdm;
    logic       alt;
    s6 = six_neg(b[4:0]);
    w6 = ones({4'h0, s6});
    if (rdp && (w6 != 4'h3 || b[4:0] == 5'h07)) begin
      s6 = ~s6;
    end
    w6 = ones({4'h0, s6});
    if (w6 > 4'h3) begin
      rdm = 1'b1;
    end else if (w6 < 4'h3) begin
      rdm = 1'b0;
    end else begin
      rdm = rdp;
    end
    // The alternate x.7 nibble avoids a run of five inside the char.
    alt = (b[7:5] == 3'h7) &&
          ((!rdm && (b[4:0] == 5'h11 || b[4:0] == 5'h12 ||
                     b[4:0] == 5'h14)) ||
           (rdm && (b[4:0] == 5'h0B || b[4:0] == 5'h0D ||
                    b[4:0] == 5'h0E)));
    s4 = alt ? 4'h7 : four_neg(b[7:5]);
    if (rdm && (ones({6'h00, s4}) != 4'h2 || b[7:5] == 3'h3)) begin
      s4 = ~s4;
    end
    enc_data = {s6, s4};
  endfunction

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------
  sce_state_s st_q;
  sce_state_s st_d;

  always_comb begin
    logic [7:0] dbyte;
    logic [9:0] k_neg;
    logic [9:0] chr;
    logic       is_k;
    logic [3:0] w;
    w     = 4'h0;
    dbyte = tx_byte;
    k_neg = SCE_K28_5_NEG;
    chr   = SCE_K28_5_NEG;
    is_k  = 1'b1;
    st_d      = st_q;
    st_d.rsv  = 1'b0;
    if (!tx_valid) begin
      k_neg = SCE_K28_5_NEG;
    end else if (!tx_special) begin
      is_k = 1'b0;
      // The pending force waits through fills and special codes, so
      // the host may pad between the helper code and its data byte.
      if (st_q.lsb_pend) begin
        dbyte[0]      = ~st_q.rd_pos;
        st_d.lsb_pend = 1'b0;
      end
    end else if (tx_byte <= SCE_C_K28_MAX) begin
      k_neg = {SCE_K28_6B_NEG, k28_four(tx_byte[2:0])};
    end else if (tx_byte[4:0] == SCE_A_K28_LOW) begin
      k_neg = {SCE_K28_6B_NEG, k28_four(tx_byte[7:5])};
    end else if (tx_byte == SCE_C_K23_7 ||
                 tx_byte == SCE_A_K23_7) begin
      k_neg = SCE_K23_7_NEG;
    end else if (tx_byte == SCE_C_K27_7 ||
                 tx_byte == SCE_A_K27_7) begin
      k_neg = SCE_K27_7_NEG;
    end else if (tx_byte == SCE_C_K29_7 ||
                 tx_byte == SCE_A_K29_7) begin
      k_neg = SCE_K29_7_NEG;
    end else if (tx_byte == SCE_C_K30_7 ||
                 tx_byte == SCE_A_K30_7) begin
      k_neg = SCE_K30_7_NEG;
    end else if (tx_byte == SCE_C_EOF_HELP) begin
      k_neg         = SCE_K28_5_NEG;
      st_d.lsb_pend = 1'b1;
    end else begin
      is_k = 1'b0;
    end

    if (is_k) begin
      // Every control character here is self-complementary by RD.
      chr = st_q.rd_pos ? ~k_neg : k_neg;
    end else if (!tx_special) begin
      chr = enc_data(dbyte, st_q.rd_pos);
    end else if (tx_byte == SCE_C_K28_5_NEG) begin
      chr = SCE_K28_5_NEG;
    end else if (tx_byte == SCE_C_K28_5_POS) begin
      chr = SCE_K28_5_POS;
    end else if (tx_byte == SCE_C_RD_VIOL) begin
      chr = st_q.rd_pos ? SCE_RDV_AT_POS : SCE_RDV_AT_NEG;
    end else if (tx_byte == SCE_C_VIOL_SYM) begin
      chr = st_q.rd_pos ? SCE_CRV_AT_POS : SCE_CRV_AT_NEG;
    end else begin
      // Reserved codes are flagged and sent as the violation symbol.
      chr      = st_q.rd_pos ? SCE_CRV_AT_POS : SCE_CRV_AT_NEG;
      st_d.rsv = 1'b1;
    end

    st_d.chr = chr;
    // A weight of five leaves disparity as it was. Judging the whole
    // character also covers the violation patterns, which have no table.
    w = ones(chr);
    if (w > 4'h5) begin
      st_d.rd_pos = 1'b1;
    end else if (w < 4'h5) begin
      st_d.rd_pos = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= SCE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // All outputs come straight from the state register.
  assign ser_char   = st_q.chr;
  assign ser_rd_pos = st_q.rd_pos;
  assign rsv_code   = st_q.rsv;

endmodule

`default_nettype wire

/* File: bench/sce_encoder_assertions.sv */
// Purpose: Port checks of the special character encoder.
// Assumes: One clock from input to ser_char; reset is synchronous.
// Notes:   Bound to every sce_encoder instance.
`timescale 1ns/1ps
`default_nettype none
module sce_encoder_assertions
  import sce_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       tx_valid,
  input wire logic       tx_special,
  input wire logic [7:0] tx_byte,
  input wire logic [9:0] ser_char,
  input wire logic       ser_rd_pos,
  input wire logic       rsv_code
);
  import sce_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic       sp;
  logic [9:0] k285;
  assign sp = tx_valid && tx_special;
  // K28.5 in the form that the current disparity selects.
  assign k285 = ser_rd_pos ? SCE_K28_5_POS : SCE_K28_5_NEG;
  property p_rdv;
    sp && tx_byte == SCE_C_RD_VIOL |=> ser_char ==
      ($past(ser_rd_pos) ? SCE_RDV_AT_POS : SCE_RDV_AT_NEG);
  endproperty
  a_rdv: assert property (p_rdv) else $error("disparity violation");
  property p_eof;
    sp && tx_byte == SCE_C_EOF_HELP |=> ser_char == $past(k285);
  endproperty
  a_eof: assert property (p_eof) else $error("end of frame char");
  property p_crv;
    sp && tx_byte == SCE_C_VIOL_SYM |=> ser_char ==
      ($past(ser_rd_pos) ? SCE_CRV_AT_POS : SCE_CRV_AT_NEG);
  endproperty
  a_crv: assert property (p_crv) else $error("violation symbol");
  property p_neg;
    sp && tx_byte == SCE_C_K28_5_NEG |=> ser_char == SCE_K28_5_NEG;
  endproperty
  a_neg: assert property (p_neg) else $error("forced negative");
  property p_pos;
    sp && tx_byte == SCE_C_K28_5_POS |=> ser_char == SCE_K28_5_POS;
  endproperty
  a_pos: assert property (p_pos) else $error("forced positive");
  property p_fill;
    !tx_valid |=> ser_char == $past(k285);
  endproperty
  a_fill: assert property (p_fill) else $error("fill char");
  property p_alt;
    sp && tx_byte[4:0] == SCE_A_K28_LOW |=> ser_char[9:4] ==
      ($past(ser_rd_pos) ? ~SCE_K28_6B_NEG : SCE_K28_6B_NEG);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate K28");
  property p_rd;
    $past(rst_n) |-> ser_rd_pos == ($countones(ser_char) > 5 ? 1'b1 :
      $countones(ser_char) < 5 ? 1'b0 : $past(ser_rd_pos));
  endproperty
  a_rd: assert property (p_rd) else $error("disparity update");
  property p_rsv;
    rsv_code |-> $past(sp) && ser_char ==
      ($past(ser_rd_pos) ? SCE_CRV_AT_POS : SCE_CRV_AT_NEG);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code");
  c_rdv: cover property (sp && tx_byte == SCE_C_RD_VIOL);
  c_eof: cover property (sp && tx_byte == 8'h22 ##1 tx_valid && !tx_special);
  c_rsv: cover property (rsv_code);
endmodule
bind sce_encoder sce_encoder_assertions u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .tx_valid(tx_valid), .tx_special(tx_special),
  .tx_byte(tx_byte), .ser_char(ser_char), .ser_rd_pos(ser_rd_pos),
  .rsv_code(rsv_code));
`default_nettype wire

/* File: bench/sce_host_model.sv */
// Purpose: Host that presents characters to the encoder.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Reserved codes go out only when the bench asks for them.
`timescale 1ns/1ps
`default_nettype none
module sce_host_model (
  input  wire logic       clk_sys,
  output logic            tx_valid,
  output logic            tx_special,
  output logic      [7:0] tx_byte
);
  logic last_k;
  initial begin
    tx_valid = 1'b0;
    tx_special = 1'b0;
    tx_byte = 8'h00;
    last_k = 1'b0;
  end
  task automatic put(input logic v, input logic s, input logic [7:0] b);
    logic [7:0] c;
    c = b;
    // A K28.7 or violation symbol before D11.x or D20.x aliases a comma.
    if (last_k && v && !s && (c[4:0] == 5'h0B || c[4:0] == 5'h14))
      c[4:0] = 5'h15;
    // The byte is meaningless on fill cycles, so the last byte is inverted.
    if (!v)
      c = ~tx_byte;
    @(posedge clk_sys);
    tx_valid <= v;
    tx_special <= s;
    tx_byte <= c;
    last_k = v && s && (c == 8'h07 || c == 8'hE0 || c == 8'hFC);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench of the special character encoder.
// Assumes: Expected characters follow from disparity tracked by hand.
// Notes:   Random traffic is judged by the bound checker only.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sce_pkg::*;
  typedef struct {int due; logic [9:0] chr; logic rd; logic rsv;} sce_exp_s;
  logic       clk_sys;
  logic       rst_n;
  wire        tx_valid;
  wire        tx_special;
  wire  [7:0] tx_byte;
  wire  [9:0] ser_char;
  wire        ser_rd_pos;
  wire        rsv_code;
  int         error_cnt;
  int         tests_run;
  int         cyc;
  int         r;
  logic       rd_m = 1'b1;
  sce_exp_s   q[$];
  logic [7:0] alt[9] = '{8'h22, 8'hE0, 8'hE1, 8'hE2, 8'hE4,
                         8'hF7, 8'hFB, 8'hFD, 8'hFE};
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  sce_host_model host (.clk_sys(clk_sys), .tx_valid(tx_valid),
    .tx_special(tx_special), .tx_byte(tx_byte));
  sce_encoder dut (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_special(tx_special), .tx_byte(tx_byte), .ser_char(ser_char),
    .ser_rd_pos(ser_rd_pos), .rsv_code(rsv_code));
  // ---------------------------------------------------------------
  // Checking.
  // ---------------------------------------------------------------
  task automatic cmp_chr(input logic [9:0] e);
    tests_run++;
    if (ser_char !== e) begin
      error_cnt++;
      $display("[ERR] ser_char exp %h got %h", e, ser_char);
    end
  endtask
  task automatic cmp_rsv(input logic e);
    tests_run++;
    if (rsv_code !== e) begin
      error_cnt++;
      $display("[ERR] rsv_code exp %b got %b", e, rsv_code);
    end
  endtask
  task automatic cmp_rd(input logic e);
    tests_run++;
    if (ser_rd_pos !== e) begin
      error_cnt++;
      $display("[ERR] ser_rd_pos exp %b got %b", e, ser_rd_pos);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic go(input logic v, s, input logic [7:0] b,
                    input logic [9:0] e);
    host.put(v, s, b);
    // Disparity follows the weight of the expected character.
    if ($countones(e) > 5)
      rd_m = 1'b1;
    else if ($countones(e) < 5)
      rd_m = 1'b0;
    q.push_back('{cyc + 2, e, rd_m, v && s && b == 8'h30});
  endtask
  always @(negedge clk_sys) begin
    cyc++;
    while (q.size() > 0 && q[0].due == cyc) begin
      cmp_chr(q[0].chr);
      cmp_rd(q[0].rd);
      cmp_rsv(q[0].rsv);
      void'(q.pop_front());
    end
  end
  initial begin
    #(5.0 * 3000);
    error_cnt++;
    final_report();
  end
  // ---------------------------------------------------------------
  // Stimulus; disparity is positive after the fill at reset exit.
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    void'($urandom(32'hB3FE));
    go(0, 0, 8'h00, SCE_K28_5_POS);
    go(0, 0, 8'h00, SCE_K28_5_NEG);
    go(1, 1, 8'hE1, SCE_K28_5_NEG);
    go(1, 1, 8'hE2, SCE_K28_5_POS);
    go(1, 1, 8'hE2, SCE_K28_5_POS);
    go(1, 1, 8'hE1, SCE_K28_5_NEG);
    go(1, 1, 8'hE4, SCE_RDV_AT_POS);
    go(1, 1, 8'hE4, SCE_RDV_AT_NEG);
    go(1, 1, 8'hE0, SCE_CRV_AT_POS);
    go(1, 1, 8'hE0, SCE_CRV_AT_NEG);
    go(1, 1, 8'h22, SCE_K28_5_POS);
    go(1, 0, 8'hB4, 10'h2AA);
    go(1, 1, 8'h22, SCE_K28_5_NEG);
    go(0, 0, 8'h00, SCE_K28_5_POS);
    go(0, 0, 8'h00, SCE_K28_5_NEG);
    go(1, 0, 8'hB5, 10'h0BA);
    go(1, 1, 8'h30, SCE_CRV_AT_POS);
    go(1, 1, 8'hBC, SCE_K28_5_NEG);
    go(1, 1, 8'h05, SCE_K28_5_POS);
    repeat (300) begin
      r = $urandom;
      case (r[2:0])
        3'h0: host.put(0, 0, 8'h00);
        3'h1: host.put(1, 1, 8'(r[15:8] % 12));
        3'h2: host.put(1, 1, {r[10:8], SCE_A_K28_LOW});
        3'h3: host.put(1, 1, alt[r[15:8] % 9]);
        default: host.put(1, 0, r[15:8]);
      endcase
    end
    host.put(0, 0, 8'h00);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    q.push_back('{cyc + 1, SCE_K28_5_NEG, SCE_RST_RD, 1'b0});
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule
`default_nettype wire
